// ==== rtl/icm_pkg.sv ====
// Package: register map, fields, modes, states and bus carriers of the capture sequencer
package icm_pkg;

  // APB register byte offsets
  localparam logic [7:0] ICM_OFF_CTRL = 8'h00;
  localparam logic [7:0] ICM_OFF_CMD = 8'h04;
  localparam logic [7:0] ICM_OFF_PERIOD = 8'h08;
  localparam logic [7:0] ICM_OFF_EXPO = 8'h0c;
  localparam logic [7:0] ICM_OFF_XLEN = 8'h10;
  localparam logic [7:0] ICM_OFF_STATUS = 8'h14;
  localparam logic [7:0] ICM_OFF_IRQ_STS = 8'h18;
  localparam logic [7:0] ICM_OFF_IRQ_MASK = 8'h1c;

  // Control register fields
  localparam int ICM_MODE_W = 3;
  localparam int ICM_CTRL_MODE_LSB = 0;
  localparam int ICM_CTRL_STD_BIT = 3;
  localparam int ICM_CTRL_GLB_BIT = 4;

  // Command register bits (write-only pulses)
  localparam int ICM_CMD_SINGLE = 0;
  localparam int ICM_CMD_CONT = 1;
  localparam int ICM_CMD_STOP = 2;

  // Status register fields
  localparam int ICM_STS_STATE_LSB = 0;
  localparam int ICM_STS_EBUSY_BIT = 5;
  localparam int ICM_STS_XBUSY_BIT = 6;
  localparam int ICM_STS_CONT_BIT = 7;
  localparam int ICM_STS_PEND_BIT = 8;

  // Interrupt status / mask bits
  localparam int ICM_IRQ_W = 3;
  localparam int ICM_IRQ_READY = 0;
  localparam int ICM_IRQ_FRAME = 1;
  localparam int ICM_IRQ_OVERRUN = 2;

  // Reset values of the timing registers, in clock cycles
  localparam logic [31:0] ICM_RST_PERIOD = 32'h0000_0400;
  localparam logic [31:0] ICM_RST_EXPO = 32'h0000_0100;
  localparam logic [31:0] ICM_RST_XLEN = 32'h0000_0200;

  // Trigger mode selection
  localparam logic [2:0] ICM_MODE_OFF = 3'h0;
  localparam logic [2:0] ICM_MODE_SW = 3'h1;
  localparam logic [2:0] ICM_MODE_HW_RISE = 3'h2;
  localparam logic [2:0] ICM_MODE_HW_FALL = 3'h3;
  localparam logic [2:0] ICM_MODE_SYNC_RISE = 3'h4;
  localparam logic [2:0] ICM_MODE_SYNC_FALL = 3'h5;

  typedef enum logic [4:0] {
    ICM_ST_IDLE = 5'b00001,
    ICM_ST_RUN = 5'b00010,
    ICM_ST_WAIT = 5'b00100,
    ICM_ST_EXPO = 5'b01000,
    ICM_ST_XFER = 5'b10000
  } icm_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } icm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } icm_apb_rsp_t;

endpackage

// ==== rtl/icm_edge_det.sv ====
// Trigger input synchroniser with selectable edge, one pulse per edge
`timescale 1ns/1ps
module icm_edge_det
  import icm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_din,
  input wire logic i_falling,
  output logic o_pulse
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } icm_edge_state_t;

  icm_edge_state_t cur_ff;
  icm_edge_state_t nxt_cur;

  // Only s2 reads s1; the edge looks at s2 against s3
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.s1 = i_din;
    nxt_cur.s2 = cur_ff.s1;
    nxt_cur.s3 = cur_ff.s2;
    nxt_cur.pulse = i_falling ? (cur_ff.s3 & ~cur_ff.s2) : (~cur_ff.s3 & cur_ff.s2);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign o_pulse = cur_ff.pulse;

  a_edge_single: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_pulse |=> !o_pulse) else $error("trigger edge produced two pulses");

endmodule // icm_edge_det

// ==== rtl/icm_timer.sv ====
// Loadable down-counter: busy for the loaded number of cycles, then a done pulse
`timescale 1ns/1ps
module icm_timer
  import icm_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic i_abort,
  input wire logic [CNT_W-1:0] i_len,
  output logic o_busy,
  output logic o_done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } icm_tmr_state_t;

  icm_tmr_state_t cur_ff;
  icm_tmr_state_t nxt_cur;

  // Load beats a running count, so a restart needs no abort first
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    if (i_abort) begin
      nxt_cur.busy = 1'b0;
    end else if (i_load) begin
      nxt_cur.cnt = (i_len == '0) ? '0 : i_len - CNT_W'(1); // Zero length acts as one
      nxt_cur.busy = 1'b1;
    end else if (cur_ff.busy) begin
      if (cur_ff.cnt == '0) begin
        nxt_cur.busy = 1'b0;
        nxt_cur.done = 1'b1;
      end else begin
        nxt_cur.cnt = cur_ff.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign o_busy = cur_ff.busy;
  assign o_done = cur_ff.done;

endmodule // icm_timer

// ==== rtl/icm_seq.sv ====
// Image capture mode sequencer: freerun, software and hardware trigger, freerun sync
// Operation
// - Freerun captures frames back to back, exposing one frame while the last is sent.
// - Freerun frame period and exposure time are separate settings used independently.
// - A freerun single capture sends the next exposed frame and keeps flash off.
// - A freerun continuous capture sends each frame that finds the link free until stopped, flash allowed.
// - Trigger modes keep the sensor idle until a software or input trigger arrives.
// - Software trigger single starts one exposure at once; continuous repeats it.
// - Hardware trigger single arms once; one trigger yields one frame, then disarms.
// - Hardware trigger continuous yields one frame per trigger and re-arms itself.
// - Freerun sync stays in freerun; a trigger aborts and restarts the frame.
// - Trigger modes run exposure and transfer strictly one after the other.
// - Standard flash everywhere but freerun single; global flash only when triggered.
// - End of a triggered transfer raises the capture-ready event.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module icm_seq
  import icm_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire icm_apb_req_t i_apb,
  output icm_apb_rsp_t o_apb,
  input wire logic i_trig_in,
  output logic o_expose,
  output logic o_xfer,
  output logic o_flash_std,
  output logic o_flash_glb,
  output logic o_irq
);

  typedef struct packed {
    icm_state_t st;
    logic [ICM_MODE_W-1:0] mode;
    logic std_en;
    logic glb_en;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] expo;
    logic [CNT_W-1:0] xlen;
    logic [CNT_W-1:0] fr_cnt;
    logic cont;
    logic pend;
    logic take;
    logic [ICM_IRQ_W-1:0] sts;
    logic [ICM_IRQ_W-1:0] mask;
    logic irq;
    logic flash_std;
    logic flash_glb;
    icm_apb_rsp_t rsp;
  } icm_seq_state_t;

  icm_seq_state_t cur_ff;
  icm_seq_state_t nxt_cur;

  logic trig_pulse;
  logic exp_busy;
  logic exp_done;
  logic xf_busy;
  logic xf_done;
  logic exp_load;
  logic xf_load;
  logic tmr_abort;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger input and the two phase timers

  icm_edge_det u_edge (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_din(i_trig_in),
    .i_falling(cur_ff.mode == ICM_MODE_HW_FALL || cur_ff.mode == ICM_MODE_SYNC_FALL),
    .o_pulse(trig_pulse)
  );

  icm_timer #(.CNT_W(CNT_W)) u_exp_tmr (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_load(exp_load),
    .i_abort(tmr_abort),
    .i_len(cur_ff.expo),
    .o_busy(exp_busy),
    .o_done(exp_done)
  );

  icm_timer #(.CNT_W(CNT_W)) u_xf_tmr (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_load(xf_load),
    .i_abort(tmr_abort),
    .i_len(cur_ff.xlen),
    .o_busy(xf_busy),
    .o_done(xf_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and mode classes

  logic wr_en;
  logic acc_en;
  logic mode_trig;
  logic mode_sync;
  logic mode_hw;
  logic mode_chg;
  logic cmd_single;
  logic cmd_cont;
  logic cmd_stop;
  logic addr_ok;

  // The write lands on the access cycle where pready is already high
  assign acc_en = i_apb.psel & i_apb.penable;
  assign wr_en = acc_en & i_apb.pwrite & cur_ff.rsp.pready;
  assign mode_hw = (cur_ff.mode == ICM_MODE_HW_RISE) || (cur_ff.mode == ICM_MODE_HW_FALL);
  assign mode_trig = mode_hw || (cur_ff.mode == ICM_MODE_SW);
  assign mode_sync = (cur_ff.mode == ICM_MODE_SYNC_RISE) || (cur_ff.mode == ICM_MODE_SYNC_FALL);
  assign mode_chg = wr_en && (i_apb.paddr == ICM_OFF_CTRL) &&
                    (i_apb.pwdata[ICM_CTRL_MODE_LSB +: ICM_MODE_W] != cur_ff.mode);
  assign cmd_single = wr_en && (i_apb.paddr == ICM_OFF_CMD) && i_apb.pwdata[ICM_CMD_SINGLE];
  assign cmd_cont = wr_en && (i_apb.paddr == ICM_OFF_CMD) && i_apb.pwdata[ICM_CMD_CONT];
  assign cmd_stop = wr_en && (i_apb.paddr == ICM_OFF_CMD) && i_apb.pwdata[ICM_CMD_STOP];
  assign addr_ok = (i_apb.paddr[7:5] == 3'h0) && (i_apb.paddr[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, registers and interrupt logic

  always_comb begin
    logic [ICM_IRQ_W-1:0] evt;
    logic [31:0] rd;
    evt = '0;
    rd = '0;
    nxt_cur = cur_ff;
    exp_load = 1'b0;
    xf_load = 1'b0;
    tmr_abort = 1'b0;

    // Register writes; period and exposure stay independent fields
    if (wr_en) begin
      case (i_apb.paddr)
        ICM_OFF_CTRL: begin
          nxt_cur.mode = i_apb.pwdata[ICM_CTRL_MODE_LSB +: ICM_MODE_W];
          nxt_cur.std_en = i_apb.pwdata[ICM_CTRL_STD_BIT];
          nxt_cur.glb_en = i_apb.pwdata[ICM_CTRL_GLB_BIT];
        end
        ICM_OFF_PERIOD: nxt_cur.period = i_apb.pwdata[CNT_W-1:0];
        ICM_OFF_EXPO: nxt_cur.expo = i_apb.pwdata[CNT_W-1:0];
        ICM_OFF_XLEN: nxt_cur.xlen = i_apb.pwdata[CNT_W-1:0];
        ICM_OFF_IRQ_MASK: nxt_cur.mask = i_apb.pwdata[ICM_IRQ_W-1:0];
        default: ;
      endcase
    end

    // Capture requests; a stop ends continuous capture after the frame in flight
    if (cmd_cont) begin
      nxt_cur.cont = 1'b1;
    end
    if (cmd_single && !mode_trig) begin
      nxt_cur.pend = 1'b1;
    end
    if (cmd_stop) begin
      nxt_cur.cont = 1'b0;
      nxt_cur.pend = 1'b0;
    end

    case (cur_ff.st)
      ICM_ST_IDLE: begin
        if (!mode_trig) begin
          nxt_cur.st = ICM_ST_RUN;
          nxt_cur.fr_cnt = '0;
        end else if (cmd_single || cmd_cont) begin
          if (cur_ff.mode == ICM_MODE_SW) begin
            exp_load = 1'b1;
            nxt_cur.st = ICM_ST_EXPO;
          end else begin
            nxt_cur.st = ICM_ST_WAIT;
          end
        end
      end
      ICM_ST_RUN: begin
        // Frame clock runs regardless of capture; a sync trigger restarts it
        if (mode_sync && trig_pulse) begin
          nxt_cur.fr_cnt = '0;
        end else if (cur_ff.fr_cnt >= cur_ff.period - CNT_W'(1)) begin
          nxt_cur.fr_cnt = '0;
        end else begin
          nxt_cur.fr_cnt = cur_ff.fr_cnt + CNT_W'(1);
        end
        if (cur_ff.fr_cnt == '0) begin
          exp_load = 1'b1;
          if (cur_ff.pend) begin
            nxt_cur.take = 1'b1;
            nxt_cur.pend = 1'b0;
          end
        end
        // Readout of the finished frame overlaps the next exposure
        if (exp_done && (cur_ff.take || cur_ff.cont)) begin
          nxt_cur.take = 1'b0;
          if (xf_busy) begin
            evt[ICM_IRQ_OVERRUN] = 1'b1; // Frame dropped, link still busy
          end else begin
            xf_load = 1'b1;
          end
        end
        if (xf_done) begin
          evt[ICM_IRQ_FRAME] = 1'b1;
        end
      end
      ICM_ST_WAIT: begin
        if (cmd_stop) begin
          nxt_cur.st = ICM_ST_IDLE;
        end else if (trig_pulse) begin
          exp_load = 1'b1;
          nxt_cur.st = ICM_ST_EXPO;
        end
      end
      ICM_ST_EXPO: begin
        if (exp_done) begin
          xf_load = 1'b1;
          nxt_cur.st = ICM_ST_XFER;
        end
      end
      ICM_ST_XFER: begin
        if (xf_done) begin
          evt[ICM_IRQ_READY] = 1'b1;
          evt[ICM_IRQ_FRAME] = 1'b1;
          if (!nxt_cur.cont) begin
            nxt_cur.st = ICM_ST_IDLE;
          end else if (cur_ff.mode == ICM_MODE_SW) begin
            exp_load = 1'b1;
            nxt_cur.st = ICM_ST_EXPO;
          end else begin
            nxt_cur.st = ICM_ST_WAIT;
          end
        end
      end
      default: nxt_cur.st = ICM_ST_IDLE;
    endcase

    // A new mode drops all capture state and starts from idle
    if (mode_chg) begin
      nxt_cur.st = ICM_ST_IDLE;
      nxt_cur.cont = 1'b0;
      nxt_cur.pend = 1'b0;
      nxt_cur.take = 1'b0;
      tmr_abort = 1'b1;
    end

    // Flash permissions follow the current mode
    nxt_cur.flash_std = exp_busy && cur_ff.std_en && (mode_trig || cur_ff.cont);
    nxt_cur.flash_glb = exp_busy && cur_ff.glb_en && mode_trig;

    // Sticky status: a new event wins over a write-one clear in the same cycle
    if (wr_en && i_apb.paddr == ICM_OFF_IRQ_STS) begin
      nxt_cur.sts = cur_ff.sts & ~i_apb.pwdata[ICM_IRQ_W-1:0];
    end
    nxt_cur.sts = nxt_cur.sts | evt;
    nxt_cur.irq = |(cur_ff.sts & cur_ff.mask);

    // Read mux
    case (i_apb.paddr)
      ICM_OFF_CTRL: begin
        rd[ICM_CTRL_MODE_LSB +: ICM_MODE_W] = cur_ff.mode;
        rd[ICM_CTRL_STD_BIT] = cur_ff.std_en;
        rd[ICM_CTRL_GLB_BIT] = cur_ff.glb_en;
      end
      ICM_OFF_PERIOD: rd[CNT_W-1:0] = cur_ff.period;
      ICM_OFF_EXPO: rd[CNT_W-1:0] = cur_ff.expo;
      ICM_OFF_XLEN: rd[CNT_W-1:0] = cur_ff.xlen;
      ICM_OFF_STATUS: begin
        rd[ICM_STS_STATE_LSB +: 5] = cur_ff.st;
        rd[ICM_STS_EBUSY_BIT] = exp_busy;
        rd[ICM_STS_XBUSY_BIT] = xf_busy;
        rd[ICM_STS_CONT_BIT] = cur_ff.cont;
        rd[ICM_STS_PEND_BIT] = cur_ff.pend | cur_ff.take;
      end
      ICM_OFF_IRQ_STS: rd[ICM_IRQ_W-1:0] = cur_ff.sts;
      ICM_OFF_IRQ_MASK: rd[ICM_IRQ_W-1:0] = cur_ff.mask;
      default: rd = '0;
    endcase

    // One wait state: pready rises on the second access cycle
    nxt_cur.rsp.pready = acc_en & ~cur_ff.rsp.pready;
    nxt_cur.rsp.prdata = (acc_en & ~cur_ff.rsp.pready & ~i_apb.pwrite) ? rd : '0;
    nxt_cur.rsp.pslverr = acc_en & ~cur_ff.rsp.pready & ~addr_ok;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cur_ff <= '0;
      cur_ff.st <= ICM_ST_IDLE;
      cur_ff.mode <= ICM_MODE_OFF;
      cur_ff.period <= CNT_W'(ICM_RST_PERIOD);
      cur_ff.expo <= CNT_W'(ICM_RST_EXPO);
      cur_ff.xlen <= CNT_W'(ICM_RST_XLEN);
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign o_apb = cur_ff.rsp;
  assign o_expose = exp_busy;
  assign o_xfer = xf_busy;
  assign o_flash_std = cur_ff.flash_std;
  assign o_flash_glb = cur_ff.flash_glb;
  assign o_irq = cur_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_run_overlap: assert property (
    cur_ff.st == ICM_ST_RUN && !mode_chg && exp_done && cur_ff.cont && !xf_busy
    |=> o_xfer) else $error("freerun frame not sent after exposure");
  a_run_wrap: assert property (
    cur_ff.st == ICM_ST_RUN && !mode_chg && !trig_pulse && cur_ff.fr_cnt == '0
    |=> o_expose) else $error("freerun frame start without exposure");
  a_expo_indep: assert property (
    wr_en && i_apb.paddr == ICM_OFF_EXPO |=> $stable(cur_ff.period))
    else $error("exposure write changed frame period");
  a_snap_noflash: assert property (
    cur_ff.st == ICM_ST_RUN && !cur_ff.cont && !mode_trig |=> !o_flash_std)
    else $error("flash in freerun single frame");
  a_trig_idle: assert property (
    cur_ff.st == ICM_ST_WAIT |-> !o_expose) else $error("exposing while waiting for trigger");
  a_sw_start: assert property (
    cur_ff.st == ICM_ST_IDLE && cur_ff.mode == ICM_MODE_SW && cmd_single && !mode_chg
    |=> cur_ff.st == ICM_ST_EXPO && o_expose) else $error("software single did not expose");
  a_hw_disarm: assert property (
    cur_ff.st == ICM_ST_XFER && xf_done && !cur_ff.cont && !cmd_cont && !mode_chg
    |=> cur_ff.st == ICM_ST_IDLE ##1 !o_expose) else $error("single trigger left armed");
  a_hw_rearm: assert property (
    cur_ff.st == ICM_ST_XFER && xf_done && cur_ff.cont && mode_hw && !cmd_stop && !mode_chg
    |=> cur_ff.st == ICM_ST_WAIT) else $error("continuous hardware trigger not re-armed");
  a_sync_restart: assert property (
    cur_ff.st == ICM_ST_RUN && mode_sync && trig_pulse && !mode_chg
    |=> cur_ff.fr_cnt == '0 ##1 o_expose) else $error("sync trigger did not restart frame");
  a_no_overlap: assert property (
    cur_ff.st inside {ICM_ST_WAIT, ICM_ST_EXPO, ICM_ST_XFER} |-> !(o_expose && o_xfer))
    else $error("exposure and transfer overlap in trigger mode");
  a_glb_flash: assert property (
    o_flash_glb |-> $past(mode_trig)) else $error("global flash outside trigger mode");
  a_ready_evt: assert property (
    cur_ff.st == ICM_ST_XFER && xf_done |=> cur_ff.sts[ICM_IRQ_READY])
    else $error("capture-ready event missing");

  c_live_frame: cover property (cur_ff.st == ICM_ST_RUN && cur_ff.cont && xf_done);
  c_sw_frame: cover property (cur_ff.st == ICM_ST_XFER && xf_done && cur_ff.mode == ICM_MODE_SW);
  c_hw_frame: cover property (cur_ff.st == ICM_ST_XFER && xf_done && mode_hw);
  c_sync_abort: cover property (cur_ff.st == ICM_ST_RUN && mode_sync && trig_pulse);

endmodule // icm_seq

// ==== tb/icm_host_model.sv ====
// Host-side partner: drives the trigger input, counts frames, flags capture timeouts
`timescale 1ns/1ps
module icm_host_model #(
  parameter int MIN_CYC = 2000000
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_fire,
  input wire logic i_falling,
  input wire logic i_arm,
  input wire logic [31:0] i_budget,
  input wire logic i_xfer,
  output logic o_trig,
  output int o_frames,
  output logic o_timeout
);
  int hold;
  int wait_c;
  logic xfer_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger pulse of 4 cycles away from the idle level; long enough for the synchroniser
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      hold <= 0; // Line rests at its idle level straight after reset
    end else if (i_fire) begin
      hold <= 4;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  assign o_trig = i_falling ^ (hold > 0);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame counting and wait limit; the limit never drops below the floor
  always @(posedge i_ref_clk) begin
    xfer_q <= i_xfer;
    if (i_rst) begin
      o_frames <= 0;
      wait_c <= 0;
      o_timeout <= 1'b0;
    end else begin
      if (xfer_q && !i_xfer) begin
        o_frames <= o_frames + 1;
      end
      if (!i_arm || (xfer_q && !i_xfer)) begin
        wait_c <= 0;
      end else begin
        wait_c <= wait_c + 1;
      end
      if (wait_c > ((i_budget > MIN_CYC) ? i_budget : MIN_CYC)) begin
        o_timeout <= 1'b1;
      end
    end
  end
endmodule // icm_host_model

// ==== tb/image_capture_mode_sequencer_tb_top.sv ====
// Testbench of the capture sequencer: APB master, capture scenarios, verdict
`timescale 1ns/1ps
module image_capture_mode_sequencer_tb_top;
  import icm_pkg::*;
  logic clk, rst, trig, expose, xfer, fs, fg, irq, fire, falling, arm, tmo;
  logic [31:0] budget;
  icm_apb_req_t req;
  icm_apb_rsp_t rsp;
  int frames, bad_count, check_count, ex_c, xf_c, ov, fs_c, fg_c, cyc, rise_t, el, pl, run, f0;
  logic ex_q;

  icm_seq #(.CNT_W(32)) dut (.i_ref_clk(clk), .i_rst(rst), .i_apb(req), .o_apb(rsp),
    .i_trig_in(trig), .o_expose(expose), .o_xfer(xfer), .o_flash_std(fs),
    .o_flash_glb(fg), .o_irq(irq));
  icm_host_model host (.i_ref_clk(clk), .i_rst(rst), .i_fire(fire),
    .i_falling(falling), .i_arm(arm), .i_budget(budget), .i_xfer(xfer), .o_trig(trig),
    .o_frames(frames), .o_timeout(tmo));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus, comparison and observation helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // No fixed latency assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic pulse();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  // Counts activity over n cycles; el and pl keep the last exposure length and period
  task automatic watch(input int n);
    ex_c = 0; xf_c = 0; ov = 0; fs_c = 0; fg_c = 0;
    repeat (n) begin
      @(posedge clk);
      cyc++;
      // Integer counters would hide unknown outputs, so flag them here
      if ($isunknown({expose, xfer, fs, fg, irq})) begin
        bad_count++;
        $display("mismatch at %0t: got %h expected %h", $time, {expose, xfer, fs, fg, irq}, 5'h0);
      end
      ex_c += expose;
      xf_c += xfer;
      ov += expose & xfer;
      fs_c += fs;
      fg_c += fg;
      if (expose && !ex_q) begin
        pl = cyc - rise_t;
        rise_t = cyc;
      end
      if (!expose && ex_q) el = run;
      run = expose ? run + 1 : 0;
      ex_q = expose;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(ICM_OFF_CTRL, 32'h0);
    rd(ICM_OFF_PERIOD, ICM_RST_PERIOD);
    rd(ICM_OFF_EXPO, ICM_RST_EXPO);
    rd(ICM_OFF_XLEN, ICM_RST_XLEN);
    rd(ICM_OFF_IRQ_MASK, 32'h0);
    rd(ICM_OFF_CMD, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
  endtask

  task automatic t_sw();
    wr(ICM_OFF_EXPO, 32'h0000_000a);
    wr(ICM_OFF_XLEN, 32'h0000_000f);
    wr(ICM_OFF_IRQ_MASK, 32'h0000_0003);
    wr(ICM_OFF_CTRL, 32'h0000_0019);
    budget <= 32'h0000_0019;
    arm <= 1'b1;
    wr(ICM_OFF_CMD, 32'h0000_0001);
    watch(60);
    chk(ex_c, 10);
    chk(xf_c, 15);
    chk(ov, 0);
    chk(fg_c > 0, 1);
    chk(irq, 1);
    rd(ICM_OFF_IRQ_STS, 32'h0000_0003);
    wr(ICM_OFF_IRQ_STS, 32'h0000_0003);
    watch(2);
    chk(irq, 0);
    wr(ICM_OFF_CMD, 32'h0000_0002);
    watch(100);
    chk(ex_c > 20, 1);
    chk(ov, 0);
    chk(tmo, 0);
    arm <= 1'b0;
    wr(ICM_OFF_CMD, 32'h0000_0004);
    watch(40);
  endtask

  task automatic t_hw_single();
    falling <= 1'b1;
    wr(ICM_OFF_CTRL, {29'h0, ICM_MODE_HW_FALL});
    wr(ICM_OFF_CMD, 32'h0000_0001);
    watch(30);
    chk(ex_c, 0);
    rd(ICM_OFF_STATUS, 32'h0000_0004);
    f0 = frames;
    pulse();
    watch(60);
    chk(ex_c, 10);
    chk(xf_c, 15);
    chk(frames - f0, 1);
    pulse();
    watch(60);
    chk(ex_c, 0);
  endtask

  task automatic t_hw_cont();
    falling <= 1'b0;
    wr(ICM_OFF_CTRL, {29'h0, ICM_MODE_HW_RISE});
    wr(ICM_OFF_CMD, 32'h0000_0002);
    repeat (2) begin
      pulse();
      watch(60);
      chk(ex_c, 10);
      chk(xf_c, 15);
    end
    wr(ICM_OFF_CMD, 32'h0000_0004);
    watch(10);
  endtask

  task automatic t_free();
    wr(ICM_OFF_PERIOD, 32'h0000_0028);
    wr(ICM_OFF_XLEN, 32'h0000_0023);
    wr(ICM_OFF_CTRL, 32'h0000_0018);
    budget <= 32'h0000_002d;
    arm <= 1'b1;
    wr(ICM_OFF_CMD, 32'h0000_0001);
    watch(120);
    chk(xf_c, 35);
    chk(fs_c, 0);
    wr(ICM_OFF_CMD, 32'h0000_0002);
    watch(200);
    chk(ov > 0, 1);
    chk(fs_c > 0, 1);
    chk(fg_c, 0);
    chk(el, 10);
    chk(pl, 40);
    chk(tmo, 0);
  endtask

  // A sync trigger in the idle part of a frame restarts the frame at once
  task automatic t_sync();
    wr(ICM_OFF_CTRL, {29'h0, ICM_MODE_SYNC_RISE});
    watch(24);
    pulse();
    watch(6);
    chk(rise_t, cyc);
    watch(40);
    chk(pl, 40);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0; rst = 1'b1; req = '0; fire = 1'b0; falling = 1'b0;
    arm = 1'b0; budget = 32'h0; ex_q = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_sw();
    t_hw_single();
    t_hw_cont();
    t_free();
    t_sync();
    summarize();
  end

  // Whole run needs about 1000 cycles; a hang is cut off well beyond that
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule // image_capture_mode_sequencer_tb_top
